/* File: tlsf_pkg.sv */
// Purpose: Shared constants and carrier types for the temperature limit status flags.
// Assumes: One 40 MHz system clock; readings and limits are 8-bit unsigned codes.
// Notes:   Offset binary codes compare correctly as unsigned in both ranges.
package tlsf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register pointers and reset values.
  localparam logic [7:0] STATUS_PTR   = 8'h02;  // Status byte pointer, read only.
  localparam logic [7:0] HYST_PTR     = 8'h21;  // Shared hysteresis pointer.
  localparam logic [7:0] HYST_RESET   = 8'h0A;  // Hysteresis value after reset.
  localparam logic [7:0] STATUS_RESET = 8'h00;  // Status byte after reset.

  // Status byte bit positions.
  localparam int BIT_BUSY       = 7;
  localparam int BIT_LOCAL_UP   = 6;
  localparam int BIT_LOCAL_LOW  = 5;
  localparam int BIT_REMOTE_UP  = 4;
  localparam int BIT_REMOTE_LOW = 3;
  localparam int BIT_OPEN       = 2;
  localparam int BIT_REMOTE_CRIT = 1;
  localparam int BIT_LOCAL_CRIT = 0;
  localparam int BIT_AGG_HIGH   = 4;
  localparam int BIT_AGG_LOW    = 3;
  localparam int BIT_AGG_CRIT   = 1;

  // Configuration register 1 bit positions.
  localparam int CFG_MASK_BIT   = 7;
  localparam int CFG_FUNC_BIT   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing of the first conversion after reset.
  localparam int CLK_PERIOD_NS        = 25;
  localparam int FIRST_CONV_MAX_NS    = 100000;
  localparam int FIRST_CONV_MAX_CYC   = FIRST_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int FIRST_CONV_DELAY_CYC = 16;
  localparam int CH_IDX_W             = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic [7:0] upper;  // High limit.
    logic [7:0] lower;  // Low limit.
    logic [7:0] crit;   // Critical limit.
  } tlsf_limits_t;

  typedef struct packed {
    logic                done;     // End of one channel conversion.
    logic [CH_IDX_W-1:0] channel;  // Channel index, zero is local.
    logic [7:0]          reading;  // Result code.
    logic                open;     // Open diode seen on this attempt.
  } tlsf_conv_t;

  typedef enum logic {
    ST_POWERUP,
    ST_RUNNING
  } tlsf_start_t;

endpackage : tlsf_pkg

/* File: tlsf_hyst_cmp.sv */
// Purpose: Comparator with hysteresis, sampled at the end of a conversion.
// Assumes: update is a one-cycle pulse carrying a valid reading.
// Notes:   The release point saturates at zero for small limits.
`timescale 1ns/1ps
module tlsf_hyst_cmp (
  input  wire logic       sys_clk,  // System clock.
  input  wire logic       rst,      // Asynchronous reset, active high.
  input  wire logic       update,   // Conversion finished for this channel.
  input  wire logic [7:0] reading,  // Latest reading.
  input  wire logic [7:0] limit,    // Trip limit.
  input  wire logic [7:0] hyst,     // Shared hysteresis value.
  output logic            state     // Comparator output.
);

  logic [7:0] releaseAt;

  // Release point; a hysteresis above the limit would wrap, so clamp it.
  assign releaseAt = (limit > hyst) ? 8'(limit - hyst) : 8'h00;

  // Set above the limit, clear only at or below the release point.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= 1'b0;
    end else if (update) begin
      if (reading > limit) begin
        state <= 1'b1;
      end else if (reading <= releaseAt) begin
        state <= 1'b0;
      end
    end
  end

endmodule : tlsf_hyst_cmp

/* File: tlsf_latch_flag.sv */
// Purpose: Sticky flag that clears on a status read once its cause is gone.
// Assumes: update and clearReq are one-cycle pulses.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps
module tlsf_latch_flag (
  input  wire logic sys_clk,    // System clock.
  input  wire logic rst,        // Asynchronous reset, active high.
  input  wire logic update,     // Conversion finished for this source.
  input  wire logic cond,       // Setting condition at this conversion.
  input  wire logic setEnable,  // Setting allowed.
  input  wire logic clearReq,   // Status read completed.
  output logic      flag,       // Sticky flag.
  output logic      condHeld    // Condition of the latest conversion.
);

  // The condition is remembered so a later read can tell whether it still holds.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      condHeld <= 1'b0;
    end else if (update) begin
      condHeld <= cond;
    end
  end

  // Set has priority; a read clears only when the cause has gone away.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (update && cond && setEnable) begin
      flag <= 1'b1;
    end else if (clearReq && !condHeld) begin
      flag <= 1'b0;
    end
  end

endmodule : tlsf_latch_flag

/* File: tlsf_flags.sv */
// Purpose: Status byte and alert pin logic of a local plus remote temperature monitor.
// Assumes: The protocol engine pulses a read request and later a byte-done strobe.
// Notes:   Channel zero is local; the per-channel layout shows channels zero and one.
// Behaviour
// - Status byte read only at pointer 02h.
// - Bit 7 shows converter busy.
// - First conversion starts well under 100 us.
// - Open flag set only on remote attempts.
// - Remote critical flag with shared hysteresis.
// - Local critical flag with shared hysteresis.
// - High flags latch in interrupt mode.
// - High flags are hysteresis comparators otherwise.
// - Low flags latch in every mode.
// - Read clears latched flags once cause gone.
// - Live flags ignore reads, update per conversion.
// - Status read never releases alert pin.
// - Latched flag rising pulls alert low in interrupt mode.
// - Aggregated critical bit; bits 6,5,0 zero.
// - Aggregated high bit follows alert function.
// - Aggregated low bit latches any channel.
// - Config bit 5 selects alert function.
// - One hysteresis value for all comparators.
// - Mask keeps alert state, pin undriven in interrupt mode.
`timescale 1ns/1ps
module tlsf_flags #(
  parameter int NUM_CH = 3  // Local channel plus remote channels.
) (
  input  wire logic               sys_clk,         // System clock, 40 MHz.
  input  wire logic               rst,             // Asynchronous reset, active high.
  input  wire logic               adcBusy,         // Converter is measuring.
  input  tlsf_pkg::tlsf_conv_t    conv,            // End-of-conversion result.
  input  tlsf_pkg::tlsf_limits_t  limits [NUM_CH], // Limits per channel.
  input  wire logic [7:0]         hystValue,       // Shared hysteresis register.
  input  wire logic [7:0]         config1,         // Configuration register 1.
  input  wire logic               aggregatedLayout,// Aggregated status layout.
  input  wire logic               regReadReq,      // Read request pulse.
  input  wire logic [7:0]         regPtr,          // Register pointer.
  input  wire logic               regByteDone,     // Read byte fully sent.
  input  wire logic               alertResponse,   // Alert response address served.
  output logic                    startConv,       // First conversion start pulse.
  output logic [7:0]              regReadData,     // Status byte returned.
  output logic                    regReadValid,    // Read data valid pulse.
  output logic                    alertPinOut,     // Alert pin level when driven.
  output logic                    alertPinOe       // Alert pin pulled low.
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: channel index field and layout need 2 to 8 channels.
  if (NUM_CH < 2 || NUM_CH > 8) begin : g_badCh
    $error("tlsf_flags: NUM_CH must be 2 to 8");
  end
  if (tlsf_pkg::FIRST_CONV_DELAY_CYC >= tlsf_pkg::FIRST_CONV_MAX_CYC) begin : g_badStart
    $error("tlsf_flags: first conversion delay too long");
  end

  logic              busy;
  logic [7:0]        statusReg;
  logic [7:0]        next_status;
  logic [7:0]        snapshot;
  logic              readPending;
  logic              statusClear;
  logic              alertFunc, alertMask;
  logic [NUM_CH-1:0] chUpdate;
  logic [NUM_CH-1:0] critCmp, highCmp;
  logic [NUM_CH-1:0] highLatch, lowLatch, lowHeld;
  logic [NUM_CH-1:0] clrHigh, clrLow;
  logic              openFlag, openUpdate;
  logic [2*NUM_CH:0] latchedVec, prevLatched;
  logic              alertPending;
  logic [12:0]       upCount;
  tlsf_pkg::tlsf_start_t startState;

  // Alert function and mask come straight from configuration register 1.
  assign alertFunc = config1[tlsf_pkg::CFG_FUNC_BIT];
  assign alertMask = config1[tlsf_pkg::CFG_MASK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Startup: the first conversion is requested a short fixed time after reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      startState <= tlsf_pkg::ST_POWERUP;
      upCount    <= 13'h0000;
      startConv  <= 1'b0;
    end else begin
      startConv <= 1'b0;
      case (startState)
        tlsf_pkg::ST_POWERUP: begin
          upCount <= upCount + 13'h0001;
          if (upCount == 13'(tlsf_pkg::FIRST_CONV_DELAY_CYC)) begin
            startConv  <= 1'b1;
            startState <= tlsf_pkg::ST_RUNNING;
          end
        end
        tlsf_pkg::ST_RUNNING: begin
          startState <= tlsf_pkg::ST_RUNNING;
        end
        default: begin
          startState <= tlsf_pkg::ST_POWERUP;
        end
      endcase
    end
  end

  // Busy follows the converter busy input one cycle later; it resets to zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= adcBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel comparators and sticky flags.
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    // Each channel samples only at the end of its own conversion.
    assign chUpdate[ch] = conv.done && (conv.channel == tlsf_pkg::CH_IDX_W'(ch));

    // Which status bit a channel's sticky flags show, so a read clears only what was seen.
    assign clrHigh[ch] = statusClear && (aggregatedLayout ? snapshot[tlsf_pkg::BIT_AGG_HIGH] :
                         (ch == 0) ? snapshot[tlsf_pkg::BIT_LOCAL_UP] : snapshot[tlsf_pkg::BIT_REMOTE_UP]);
    assign clrLow[ch]  = statusClear && (aggregatedLayout ? snapshot[tlsf_pkg::BIT_AGG_LOW] :
                         (ch == 0) ? snapshot[tlsf_pkg::BIT_LOCAL_LOW] : snapshot[tlsf_pkg::BIT_REMOTE_LOW]);

    // Critical comparator, released at limit minus the shared hysteresis.
    tlsf_hyst_cmp u_crit (
      .sys_clk (sys_clk),
      .rst     (rst),
      .update  (chUpdate[ch]),
      .reading (conv.reading),
      .limit   (limits[ch].crit),
      .hyst    (hystValue),
      .state   (critCmp[ch])
    );

    // High limit comparator used in secondary critical mode.
    tlsf_hyst_cmp u_high (
      .sys_clk (sys_clk),
      .rst     (rst),
      .update  (chUpdate[ch]),
      .reading (conv.reading),
      .limit   (limits[ch].upper),
      .hyst    (hystValue),
      .state   (highCmp[ch])
    );

    // Sticky high flag, set only while in interrupt mode.
    tlsf_latch_flag u_highLatch (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .update    (chUpdate[ch]),
      .cond      (conv.reading > limits[ch].upper),
      .setEnable (!alertFunc),
      .clearReq  (clrHigh[ch]),
      .flag      (highLatch[ch]),
      .condHeld  ()
    );

    // Sticky low flag, independent of the alert function.
    tlsf_latch_flag u_lowLatch (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .update    (chUpdate[ch]),
      .cond      (conv.reading < limits[ch].lower),
      .setEnable (1'b1),
      .clearReq  (clrLow[ch]),
      .flag      (lowLatch[ch]),
      .condHeld  (lowHeld[ch])
    );
  end

  // Open detection is only meaningful while a remote channel converts.
  assign openUpdate = conv.done && (conv.channel != '0);

  tlsf_latch_flag u_openLatch (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .update    (openUpdate),
    .cond      (conv.open),
    .setEnable (1'b1),
    .clearReq  (statusClear && snapshot[tlsf_pkg::BIT_OPEN]),
    .flag      (openFlag),
    .condHeld  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status byte assembly for both layouts.
  always_comb begin
    next_status = tlsf_pkg::STATUS_RESET;
    next_status[tlsf_pkg::BIT_BUSY] = busy;
    next_status[tlsf_pkg::BIT_OPEN] = openFlag;
    if (aggregatedLayout) begin
      // Bits 6, 5 and 0 stay at zero in this layout.
      next_status[tlsf_pkg::BIT_AGG_CRIT] = |critCmp;
      next_status[tlsf_pkg::BIT_AGG_HIGH] = alertFunc ? |highCmp : |highLatch;
      next_status[tlsf_pkg::BIT_AGG_LOW]  = |lowLatch;
    end else begin
      next_status[tlsf_pkg::BIT_LOCAL_UP]    = alertFunc ? highCmp[0] : highLatch[0];
      next_status[tlsf_pkg::BIT_REMOTE_UP]   = alertFunc ? highCmp[1] : highLatch[1];
      next_status[tlsf_pkg::BIT_LOCAL_LOW]   = lowLatch[0];
      next_status[tlsf_pkg::BIT_REMOTE_LOW]  = lowLatch[1];
      next_status[tlsf_pkg::BIT_REMOTE_CRIT] = critCmp[1];
      next_status[tlsf_pkg::BIT_LOCAL_CRIT]  = critCmp[0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      statusReg <= tlsf_pkg::STATUS_RESET;
    end else begin
      statusReg <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. There is no write port, so nothing outside can alter the byte.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regReadData  <= 8'h00;
      regReadValid <= 1'b0;
      snapshot     <= 8'h00;
    end else begin
      regReadValid <= 1'b0;
      if (regReadReq && regPtr == tlsf_pkg::STATUS_PTR) begin
        regReadData  <= statusReg;
        regReadValid <= 1'b1;
        snapshot     <= statusReg;
      end
    end
  end

  // Clearing waits for the byte to leave, so the host sees every flag set before.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readPending <= 1'b0;
    end else if (regReadReq && regPtr == tlsf_pkg::STATUS_PTR) begin
      readPending <= 1'b1;
    end else if (regByteDone) begin
      readPending <= 1'b0;
    end
  end

  assign statusClear = readPending && regByteDone;

  ////////////////////////////////////////////////////////////////////////////
  // Alert pin. In interrupt mode any sticky flag rising arms the alert; only the response command disarms it.
  assign latchedVec = {highLatch, lowLatch, openFlag};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevLatched <= '0;
    end else begin
      prevLatched <= latchedVec;
    end
  end

  // A new rise in the response cycle wins, so the host is not left unaware.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alertPending <= 1'b0;
    end else if (!alertFunc && |(latchedVec & ~prevLatched)) begin
      alertPending <= 1'b1;
    end else if (alertResponse) begin
      alertPending <= 1'b0;
    end
  end

  // Open-drain drive; in interrupt mode the mask hides the pin but the pending state is kept.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alertPinOut <= 1'b0;
      alertPinOe  <= 1'b0;
    end else begin
      alertPinOut <= 1'b0;
      alertPinOe  <= alertFunc ? |highCmp : (alertPending && !alertMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  logic statusHit;
  assign statusHit = regReadReq && regPtr == tlsf_pkg::STATUS_PTR;
  property p_readData;
    @(posedge sys_clk) disable iff (rst) statusHit |=> regReadValid && regReadData == $past(statusReg);
  endproperty
  a_readData: assert property (p_readData) else $error("status read data wrong");
  property p_busy;
    @(posedge sys_clk) disable iff (rst) ##2 statusReg[tlsf_pkg::BIT_BUSY] == $past(adcBusy, 2);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit does not follow converter");
  property p_firstConv;
    @(posedge sys_clk) disable iff (rst)
      startState == tlsf_pkg::ST_POWERUP |-> upCount < 13'(tlsf_pkg::FIRST_CONV_MAX_CYC);
  endproperty
  a_firstConv: assert property (p_firstConv) else $error("first conversion too late");
  property p_openCause;
    @(posedge sys_clk) disable iff (rst) $rose(openFlag) |-> $past(openUpdate && conv.open);
  endproperty
  a_openCause: assert property (p_openCause) else $error("open flag set without remote cause");
  property p_remoteCrit;
    @(posedge sys_clk) disable iff (rst)
      (!aggregatedLayout && chUpdate[1] && conv.reading > limits[1].crit) ##1 !aggregatedLayout
      |=> statusReg[tlsf_pkg::BIT_REMOTE_CRIT];
  endproperty
  a_remoteCrit: assert property (p_remoteCrit) else $error("remote critical bit not set");
  property p_localCrit;
    @(posedge sys_clk) disable iff (rst)
      (!aggregatedLayout && chUpdate[0] && conv.reading > limits[0].crit) ##1 !aggregatedLayout
      |=> statusReg[tlsf_pkg::BIT_LOCAL_CRIT];
  endproperty
  a_localCrit: assert property (p_localCrit) else $error("local critical bit not set");
  property p_readKeep;
    @(posedge sys_clk) disable iff (rst) statusClear && lowLatch[0] && lowHeld[0] |=> lowLatch[0];
  endproperty
  a_readKeep: assert property (p_readKeep) else $error("low flag cleared while cause holds");
  property p_readNoRelease;
    @(posedge sys_clk) disable iff (rst) alertPending && statusClear && !alertResponse |=> alertPending;
  endproperty
  a_readNoRelease: assert property (p_readNoRelease) else $error("status read released alert");
  property p_alertRise;
    @(posedge sys_clk) disable iff (rst)
      (!alertFunc && !alertMask && |(latchedVec & ~prevLatched)) ##1 (!alertFunc && !alertMask) |=> alertPinOe;
  endproperty
  a_alertRise: assert property (p_alertRise) else $error("alert not driven after flag rise");
  property p_mask;
    @(posedge sys_clk) disable iff (rst) alertMask && !alertFunc |=> !alertPinOe;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert drove pin");
  property p_aggZero;
    @(posedge sys_clk) disable iff (rst) aggregatedLayout |=> statusReg[6:5] == 2'h0 && !statusReg[0];
  endproperty
  a_aggZero: assert property (p_aggZero) else $error("aggregated layout unused bits set");
  c_start:  cover property (@(posedge sys_clk) disable iff (rst) startConv);
  c_read:   cover property (@(posedge sys_clk) disable iff (rst) regReadValid && regReadData != 8'h00);
  c_alert:  cover property (@(posedge sys_clk) disable iff (rst) $rose(alertPinOe) && !alertFunc);
  c_second: cover property (@(posedge sys_clk) disable iff (rst) alertFunc && alertPinOe);

endmodule : tlsf_flags

/* File: tlsf_host_model.sv */
// Purpose: Host model that reads the status byte and serves the alert pin.
// Assumes: The host changes its requests at the falling clock edge.
// Notes:   The idle pointer shows the inverse of the last one, never a stale copy.
`timescale 1ns/1ps
module tlsf_host_model (
  input  wire logic       sys_clk,       // System clock.
  input  wire logic       regReadValid,  // Read data valid pulse.
  input  wire logic [7:0] regReadData,   // Returned byte.
  output logic            regReadReq,    // Read request pulse.
  output logic [7:0]      regPtr,        // Register pointer.
  output logic            regByteDone,   // Byte fully received.
  output logic            alertResponse  // Alert response served.
);
  // Idle levels at time zero.
  initial begin
    regReadReq = 1'b0;
    regPtr = 8'hFF;
    regByteDone = 1'b0;
    alertResponse = 1'b0;
  end

  // The done strobe follows only a delivered byte, so a refused read clears nothing.
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic got);
    got = 1'b0;
    data = 8'h00;
    @(negedge sys_clk);
    regReadReq = 1'b1;
    regPtr = ptr;
    // Valid stands only for the cycle after the taking edge, so it is looked at on the very next falling edge.
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge sys_clk);
      regReadReq = 1'b0;
      regPtr = ~ptr;
      if (regReadValid === 1'b1) begin
        got = 1'b1;
        data = regReadData;
      end
    end
    if (got) begin
      regByteDone = 1'b1;
      @(negedge sys_clk);
      regByteDone = 1'b0;
    end
  endtask : read_reg

  // A status read leaves the pin alone; in interrupt mode only this command releases it.
  task automatic ack_alert();
    @(negedge sys_clk);
    alertResponse = 1'b1;
    @(negedge sys_clk);
    alertResponse = 1'b0;
  endtask : ack_alert
endmodule : tlsf_host_model

/* File: tlsf_flags_test.sv */
// Purpose: Self-checking bench for the status byte and the alert pin.
// Assumes: Limits 70h high, 10h low, 60h critical on both channels.
// Notes:   Hysteresis stays at its reset value, so releases sit at limit minus 0Ah.
`timescale 1ns/1ps
module tlsf_flags_test;
  logic                   sys_clk, rst, adcBusy, aggregatedLayout, seen, got;
  logic                   regReadReq, regByteDone, alertResponse;
  logic                   startConv, regReadValid, alertPinOut, alertPinOe;
  logic [7:0]             hystValue, config1, regPtr, regReadData, rd;
  tlsf_pkg::tlsf_conv_t   conv;
  tlsf_pkg::tlsf_limits_t limits [2];
  int                     numErrors = 0, numChecks = 0, cyc = 0;

  tlsf_flags #(.NUM_CH(2)) u_tlsf_flags (.sys_clk(sys_clk), .rst(rst), .adcBusy(adcBusy),
    .conv(conv), .limits(limits), .hystValue(hystValue), .config1(config1),
    .aggregatedLayout(aggregatedLayout), .regReadReq(regReadReq), .regPtr(regPtr),
    .regByteDone(regByteDone), .alertResponse(alertResponse), .startConv(startConv),
    .regReadData(regReadData), .regReadValid(regReadValid), .alertPinOut(alertPinOut),
    .alertPinOe(alertPinOe));
  tlsf_host_model u_tlsf_host_model (.sys_clk(sys_clk), .regReadValid(regReadValid),
    .regReadData(regReadData), .regReadReq(regReadReq), .regPtr(regPtr),
    .regByteDone(regByteDone), .alertResponse(alertResponse));

  ////////////////////////////////////////////////////////////////
  // Compares count every check and report a mismatch at once.
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    numChecks++;
    if (g !== e) begin
      numErrors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic rd_chk(input logic [7:0] e);
    u_tlsf_host_model.read_reg(tlsf_pkg::STATUS_PTR, rd, got);
    chk1(got, 1'b1);
    chk8(rd, e);
  endtask : rd_chk
  // Waits long enough for the status byte and the alert pin to follow.
  task automatic cv(input logic [2:0] ch, input logic [7:0] v, input logic op);
    @(negedge sys_clk);
    conv = {1'b1, ch, v, op};
    @(negedge sys_clk);
    conv.done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : cv
  task automatic close_out();
    $display("errors=%0d checks=%0d", numErrors, numChecks);
    if (numErrors == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////
  // Clock, and a ceiling far above the few hundred cycles the run needs.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      numErrors++;
      close_out();
    end
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    adcBusy = 1'b0;
    aggregatedLayout = 1'b0;
    hystValue = tlsf_pkg::HYST_RESET;
    config1 = 8'h00;
    conv = '0;
    seen = 1'b0;
    foreach (limits[i]) limits[i] = {8'h70, 8'h10, 8'h60};
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(negedge sys_clk);
      seen = startConv;
    end
    chk1(seen, 1'b1);
    rd_chk(tlsf_pkg::STATUS_RESET);
    u_tlsf_host_model.read_reg(8'h03, rd, got);
    chk1(got, 1'b0);
    adcBusy = 1'b1;
    repeat (3) @(negedge sys_clk);
    rd_chk(8'h80);
    adcBusy = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd_chk(8'h00);
    // Critical flags hold just above the release point and ignore reads.
    for (int ch = 0; ch < 2; ch++) begin
      cv(3'(ch), 8'h65, 1'b0);
      rd_chk(8'h01 << ch);
      rd_chk(8'h01 << ch);
      cv(3'(ch), 8'h57, 1'b0);
      rd_chk(8'h01 << ch);
      cv(3'(ch), 8'h56, 1'b0);
      rd_chk(8'h00);
    end
    cv(3'd0, 8'h75, 1'b0);
    chk1(alertPinOe, 1'b1);
    chk1(alertPinOut, 1'b0);
    rd_chk(8'h41);
    rd_chk(8'h41);
    cv(3'd0, 8'h30, 1'b0);
    rd_chk(8'h40);
    rd_chk(8'h00);
    chk1(alertPinOe, 1'b1);
    u_tlsf_host_model.ack_alert();
    repeat (2) @(negedge sys_clk);
    chk1(alertPinOe, 1'b0);
    // Open on the remote channel sets the open flag; both low flags latch with it.
    cv(3'd1, 8'h05, 1'b1);
    cv(3'd0, 8'h05, 1'b1);
    rd_chk(8'h2C);
    rd_chk(8'h2C);
    cv(3'd1, 8'h30, 1'b0);
    cv(3'd0, 8'h30, 1'b0);
    rd_chk(8'h2C);
    rd_chk(8'h00);
    u_tlsf_host_model.ack_alert();
    config1 = 8'h80;
    cv(3'd1, 8'h05, 1'b0);
    chk1(alertPinOe, 1'b0);
    config1 = 8'h00;
    repeat (3) @(negedge sys_clk);
    chk1(alertPinOe, 1'b1);
    u_tlsf_host_model.ack_alert();
    cv(3'd1, 8'h30, 1'b0);
    rd_chk(8'h08);
    rd_chk(8'h00);
    config1 = 8'h20;
    cv(3'd0, 8'h75, 1'b0);
    chk1(alertPinOe, 1'b1);
    rd_chk(8'h41);
    cv(3'd0, 8'h67, 1'b0);
    rd_chk(8'h41);
    cv(3'd0, 8'h66, 1'b0);
    rd_chk(8'h01);
    chk1(alertPinOe, 1'b0);
    config1 = 8'h00;
    cv(3'd0, 8'h30, 1'b0);
    aggregatedLayout = 1'b1;
    cv(3'd0, 8'h75, 1'b0);
    rd_chk(8'h12);
    cv(3'd1, 8'h05, 1'b0);
    rd_chk(8'h1A);
    close_out();
  end
endmodule : tlsf_flags_test
